// *** rtl/pcr_map.vh ***
// Register offsets, field positions, page codes and reset values of the paged register front end
`ifndef PCR_MAP_VH
`define PCR_MAP_VH
`define PCR_ADDR_W 16
`define PCR_A_SWRST 16'h0000
`define PCR_A_PAGE0 16'h0002
`define PCR_A_PAGE1 16'h0003
`define PCR_A_PAGE2 16'h0004
`define PCR_A_PORTCFG 16'h0010
`define PCR_A_ADCPG 16'h0011
`define PCR_A_MSTPG 16'h0012
`define PCR_A_PDN 16'h0020
`define PCR_A_PWR2B 16'h0027
`define PCR_A_AGCRST 16'h002b
`define PCR_A_OSEL1 16'h0032
`define PCR_A_OSEL4 16'h0035
`define PCR_A_PDIR 16'h0037
`define PCR_A_INSEL 16'h0038
`define PCR_A_PGSEL_LO 16'h4003
`define PCR_A_PGSEL_HI 16'h4004
`define PCR_A_DIGRST 16'h6000
`define PCR_A_LMODE_A 16'h6002
`define PCR_A_SCR_A 16'h6006
`define PCR_A_LMODE_B 16'h7002
`define PCR_A_SCR_B 16'h7006
`define PCR_A_DDC_EN 16'h5000
`define PCR_A_DEC_A 16'h5001
`define PCR_A_NCO_LO_A 16'h5007
`define PCR_A_NCO_HI_A 16'h5008
`define PCR_A_GAIN_A 16'h5014
`define PCR_A_DEC_B 16'h5801
`define PCR_A_NCO_LO_B 16'h5807
`define PCR_A_NCO_HI_B 16'h5808
`define PCR_A_GAIN_B 16'h5814
`define PCR_BIT_RST_HI 7
`define PCR_BIT_RST_LO 0
`define PCR_BIT_3WIRE 0
`define PCR_BIT_MSTPG 2
`define PCR_BIT_GPDN 0
`define PCR_BIT_SCR 7
`define PCR_PG_MAIN_A 24'h680000
`define PCR_PG_MAIN_B 24'h680100
`define PCR_PG_FUNC_A 24'h610000
`define PCR_PG_FUNC_B 24'h610100
`define PCR_PG_LINK 24'h690000
`define PCR_RST_VAL 8'h00
`define PCR_DEC_BY8 8'h02
`define PCR_MASK_PWR2B 8'h01
`define PCR_MASK_AGCRST 8'h10
`define PCR_MASK_PDIR 8'h0f
`define PCR_MASK_INSEL 8'h33
`define PCR_MASK_PORTCFG 8'h01
`define PCR_MASK_MSTPG 8'h04
`define PCR_MASK_PDN 8'h13
`define PCR_MASK_SCR 8'h80
`define PCR_MASK_BIT0 8'h01
`define PCR_SPI_CNT_W 5
`endif

// *** rtl/pcr_pin_ram.v ***
// Small register memory for the four pin output select words, registered read
module pcr_pin_ram (
  input wire clk,
  input wire we,
  input wire [1:0] waddr,
  input wire [7:0] wdata,
  input wire [1:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:3];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** rtl/pcr_top.v ***
// Serial-port register front end with paged digital bank and datapath control outputs
//
// How it works
// - Writing both reset bits at 000h pulses an internal reset and the bits read back zero.
// - A 24-bit page selector is held, its low byte at 002h, read/write, reset to zero.
// - Page values decode to channel A/B main, channel A/B function and link digital pages.
// - In the link page, 80h to 6006h or 7006h enables the channel A or B scrambler.
// - In a main page, 01h then 00h at 6000h asserts then releases that channel's reset.
// - Writing 68h to 4004h and 01h to 4003h selects the channel B main page.
// - In the link page, 01h at 6002h or 7002h sets link mode bit 0 of channel A or B.
// - Writing 01h to 5000h enables the channel A down-converter.
// - Writing 02h to 5001h or 5801h selects decimate-by-8 complex output.
// - The 16-bit oscillator word sits low byte at x007h and high byte at x008h.
// - Writing 01h to 5014h or 5814h turns on the 6 dB digital gain.
// - Bit 0 of 010h picks four-wire (0) or three-wire (1) serial port operation.
// - Bit 2 of 012h selects the master page while the ADC page select is zero.
`include "pcr_map.vh"
module pcr_top (
  input wire CLK_SYS,
  input wire RST,
  input wire SEN_N,
  input wire SCLK,
  input wire SERIAL_DATA_PIN_I,
  output reg SERIAL_DATA_PIN_O,
  output reg SERIAL_DATA_PIN_OE_N,
  output reg SDOUT,
  output reg SOFT_RST,
  output reg GLOBAL_PDN,
  output reg [1:0] DIG_RST,
  output reg [1:0] SCRAMBLE_EN,
  output reg [1:0] LINK_MODE_BIT0,
  output reg DDC_EN,
  output reg [1:0] DEC_BY8,
  output reg [15:0] NCO_WORD_A,
  output reg [15:0] NCO_WORD_B,
  output reg [1:0] GAIN_6DB,
  output reg [3:0] PIN_DIR
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  // Agreement filters one-cycle glitches on the slow serial pins
  // Pins in order: enable (idles high), serial clock, data in
  wire [2:0] pin_raw = {SERIAL_DATA_PIN_I, SCLK, SEN_N};
  wire [2:0] pin_idle = 3'b001;
  wire [2:0] pin_q;
  wire sen_q = pin_q[0];
  wire sclk_q = pin_q[1];
  wire sdi_q = pin_q[2];
  reg sclk_prev_r;
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_sync
      reg [2:0] stg_r;
      reg q_r;
      always @(posedge CLK_SYS) begin
        stg_r <= {stg_r[1:0], pin_raw[p]};
        if (RST) begin
          q_r <= pin_idle[p];
        end else if (stg_r[1] == stg_r[2]) begin
          q_r <= stg_r[2];
        end
      end
      assign pin_q[p] = q_r;
    end
  endgenerate
  // Previous clock level starts at the pin's idle level, so no false edge follows reset
  always @(posedge CLK_SYS) begin
    if (RST) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_q;
    end
  end
  wire sclk_rise = sclk_q & ~sclk_prev_r;
  wire sclk_fall = ~sclk_q & sclk_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame: read flag, 15 address bits MSB first, then 8 data bits
  // Edges past the 24th are ignored so a long burst cannot shift in junk
  // A frame cut short by the enable going high clears all frame state
  reg [`PCR_SPI_CNT_W-1:0] bit_cnt_r;
  reg [23:0] shift_r;
  reg [7:0] rd_shift_r;
  reg wr_pulse_r;
  reg rd_load_r;
  reg [15:0] wr_addr_r;
  reg [7:0] wr_data_r;
  reg is_read_r;
  reg three_wire_r;
  wire [23:0] shift_nxt = {shift_r[22:0], sdi_q};
  always @(posedge CLK_SYS) begin
    if (RST || sen_q) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 24'h000000;
      wr_pulse_r <= 1'b0;
      rd_load_r <= 1'b0;
      wr_addr_r <= 16'h0000;
      wr_data_r <= 8'h00;
      is_read_r <= 1'b0;
    end else begin
      wr_pulse_r <= 1'b0;
      rd_load_r <= 1'b0;
      if (sclk_rise && bit_cnt_r != 5'h18) begin
        shift_r <= shift_nxt;
        bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == 5'h0f) begin
          // Address complete: fetch read data before the data phase starts
          is_read_r <= shift_nxt[15];
          wr_addr_r <= {1'b0, shift_nxt[14:0]};
          rd_load_r <= shift_nxt[15];
        end
        if (bit_cnt_r == 5'h17 && !is_read_r) begin
          wr_data_r <= shift_nxt[7:0];
          wr_pulse_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Paging state
  // Writes to 4003h and 4004h also load the middle and top page bytes at 003h and 004h; reads of 4003h and 4004h return 00h
  reg [23:0] page_r;
  reg [7:0] bank_lo_r;
  reg [7:0] bank_hi_r;
  reg master_pg_r;
  reg [7:0] adc_pg_r;
  reg [7:0] pwr2b_r;
  reg [7:0] agcrst_r;
  reg [7:0] insel_r;
  reg [1:0] swrst_cnt_r;
  // Page decode
  wire pg_main_a = (page_r == `PCR_PG_MAIN_A);
  wire pg_main_b = (page_r == `PCR_PG_MAIN_B);
  wire pg_link = (page_r == `PCR_PG_LINK);
  wire pg_func = (page_r == `PCR_PG_FUNC_A) || (page_r == `PCR_PG_FUNC_B);
  wire [15:0] a = wr_addr_r;
  wire [7:0] d = wr_data_r;
  wire gen_space = ~master_pg_r;
  wire osel_hit = (a >= `PCR_A_OSEL1) && (a <= `PCR_A_OSEL4) && gen_space;
  wire swrst_go = wr_pulse_r && gen_space && (a == `PCR_A_SWRST)
                  && d[`PCR_BIT_RST_HI] && d[`PCR_BIT_RST_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel paged controls; channel B sits 1000h above A in the link page
  // and 800h above A in the datapath page, so both share one loop
  // Each next value holds the current one unless its own address is written
  wire wr_gen = wr_pulse_r && gen_space;
  wire [1:0] dig_rst_nxt;
  wire [1:0] scr_nxt;
  wire [1:0] lmode_nxt;
  wire [1:0] dec_nxt;
  wire [1:0] gain_nxt;
  wire [31:0] nco_nxt;
  wire [31:0] nco_cur = {NCO_WORD_B, NCO_WORD_A};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire main_pg = (ch == 0) ? pg_main_a : pg_main_b;
      wire [15:0] a_scr = (ch == 0) ? `PCR_A_SCR_A : `PCR_A_SCR_B;
      wire [15:0] a_lmode = (ch == 0) ? `PCR_A_LMODE_A : `PCR_A_LMODE_B;
      wire [15:0] a_dec = (ch == 0) ? `PCR_A_DEC_A : `PCR_A_DEC_B;
      wire [15:0] a_gain = (ch == 0) ? `PCR_A_GAIN_A : `PCR_A_GAIN_B;
      wire [15:0] a_nco_lo = (ch == 0) ? `PCR_A_NCO_LO_A : `PCR_A_NCO_LO_B;
      wire [15:0] a_nco_hi = (ch == 0) ? `PCR_A_NCO_HI_A : `PCR_A_NCO_HI_B;
      // Both channels share 6000h; the selected main page picks which reset moves
      assign dig_rst_nxt[ch] = (wr_gen && main_pg && a == `PCR_A_DIGRST) ? d[0]
                               : DIG_RST[ch];
      assign scr_nxt[ch] = (wr_gen && pg_link && a == a_scr) ? d[`PCR_BIT_SCR]
                           : SCRAMBLE_EN[ch];
      assign lmode_nxt[ch] = (wr_gen && pg_link && a == a_lmode) ? d[0]
                             : LINK_MODE_BIT0[ch];
      assign dec_nxt[ch] = (wr_gen && a == a_dec) ? (d == `PCR_DEC_BY8)
                           : DEC_BY8[ch];
      assign gain_nxt[ch] = (wr_gen && a == a_gain) ? d[0] : GAIN_6DB[ch];
      assign nco_nxt[16*ch +: 8] = (wr_gen && a == a_nco_lo) ? d
                                   : nco_cur[16*ch +: 8];
      assign nco_nxt[16*ch+8 +: 8] = (wr_gen && a == a_nco_hi) ? d
                                     : nco_cur[16*ch+8 +: 8];
    end
  endgenerate

  always @(posedge CLK_SYS) begin
    if (RST || swrst_go) begin
      page_r <= 24'h000000;
      bank_lo_r <= `PCR_RST_VAL;
      bank_hi_r <= `PCR_RST_VAL;
      master_pg_r <= 1'b0;
      adc_pg_r <= `PCR_RST_VAL;
      three_wire_r <= 1'b0;
      pwr2b_r <= `PCR_RST_VAL;
      agcrst_r <= `PCR_RST_VAL;
      insel_r <= `PCR_RST_VAL;
      PIN_DIR <= 4'h0;
      GLOBAL_PDN <= 1'b0;
      DIG_RST <= 2'b00;
      SCRAMBLE_EN <= 2'b00;
      LINK_MODE_BIT0 <= 2'b00;
      DDC_EN <= 1'b0;
      DEC_BY8 <= 2'b00;
      NCO_WORD_A <= 16'h0000;
      NCO_WORD_B <= 16'h0000;
      GAIN_6DB <= 2'b00;
    end else begin
      DIG_RST <= dig_rst_nxt;
      SCRAMBLE_EN <= scr_nxt;
      LINK_MODE_BIT0 <= lmode_nxt;
      DEC_BY8 <= dec_nxt;
      GAIN_6DB <= gain_nxt;
      NCO_WORD_A <= nco_nxt[15:0];
      NCO_WORD_B <= nco_nxt[31:16];
      if (wr_pulse_r) begin
      if (gen_space) begin
        case (a)
          `PCR_A_PAGE0: page_r[7:0] <= d;
          `PCR_A_PAGE1: page_r[15:8] <= d;
          `PCR_A_PAGE2: page_r[23:16] <= d;
          `PCR_A_PGSEL_LO: page_r[15:8] <= d;
          `PCR_A_PGSEL_HI: page_r[23:16] <= d;
          `PCR_A_PORTCFG: three_wire_r <= d[`PCR_BIT_3WIRE];
          `PCR_A_ADCPG: adc_pg_r <= d;
          `PCR_A_MSTPG: master_pg_r <= d[`PCR_BIT_MSTPG] && (adc_pg_r == 8'h00);
          `PCR_A_PWR2B: pwr2b_r <= d & `PCR_MASK_PWR2B;
          `PCR_A_AGCRST: agcrst_r <= d & `PCR_MASK_AGCRST;
          `PCR_A_PDIR: PIN_DIR <= d[3:0];
          `PCR_A_INSEL: insel_r <= d & `PCR_MASK_INSEL;
          `PCR_A_DDC_EN: DDC_EN <= d[0];
          default: begin
          end
        endcase
      end else begin
        // Master page space: power control, plus way back out via 012h
        case (a)
          `PCR_A_PDN: GLOBAL_PDN <= d[`PCR_BIT_GPDN];
          `PCR_A_MSTPG: master_pg_r <= d[`PCR_BIT_MSTPG];
          default: begin
          end
        endcase
      end
    end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software reset pulse, held four cycles so downstream logic sees it
  // The counter, not the bits of 000h, carries the pulse, so those bits read zero
  always @(posedge CLK_SYS) begin
    if (RST) begin
      swrst_cnt_r <= 2'b00;
      SOFT_RST <= 1'b0;
    end else if (swrst_go) begin
      swrst_cnt_r <= 2'b11;
      SOFT_RST <= 1'b1;
    end else if (swrst_cnt_r != 2'b00) begin
      swrst_cnt_r <= swrst_cnt_r - 2'b01;
      SOFT_RST <= 1'b1;
    end else begin
      SOFT_RST <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin output select words in the small memory
  wire [7:0] osel_rdata;
  pcr_pin_ram u_ram (
    .clk(CLK_SYS),
    .we(wr_pulse_r && osel_hit),
    .waddr(a[1:0] - 2'b10),
    .wdata(d),
    .raddr(a[1:0] - 2'b10),
    .rdata(osel_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read back; reset bits of 000h always read zero since 000h has no register and falls to the default
  // Read data is loaded one cycle after the address so that the pin memory
  // has its registered output ready; unmapped addresses read 00h
  reg [7:0] rd_mux;
  reg rd_osel_r;
  reg rd_load_d_r;
  always @* begin
    rd_mux = 8'h00;
    case (a)
      `PCR_A_PAGE0: rd_mux = page_r[7:0];
      `PCR_A_PAGE1: rd_mux = page_r[15:8];
      `PCR_A_PAGE2: rd_mux = page_r[23:16];
      `PCR_A_PORTCFG: rd_mux = {7'h00, three_wire_r};
      `PCR_A_ADCPG: rd_mux = adc_pg_r;
      `PCR_A_MSTPG: rd_mux = {5'h00, master_pg_r, 2'b00};
      `PCR_A_PWR2B: rd_mux = pwr2b_r;
      `PCR_A_AGCRST: rd_mux = agcrst_r;
      `PCR_A_PDIR: rd_mux = {4'h0, PIN_DIR};
      `PCR_A_INSEL: rd_mux = insel_r;
      `PCR_A_SCR_A: rd_mux = {SCRAMBLE_EN[0], 7'h00};
      `PCR_A_SCR_B: rd_mux = {SCRAMBLE_EN[1], 7'h00};
      `PCR_A_NCO_LO_A: rd_mux = NCO_WORD_A[7:0];
      `PCR_A_NCO_HI_A: rd_mux = NCO_WORD_A[15:8];
      `PCR_A_NCO_LO_B: rd_mux = NCO_WORD_B[7:0];
      `PCR_A_NCO_HI_B: rd_mux = NCO_WORD_B[15:8];
      `PCR_A_DIGRST: rd_mux = {7'h00, pg_main_b ? DIG_RST[1] : DIG_RST[0]};
      `PCR_A_LMODE_A: rd_mux = {7'h00, LINK_MODE_BIT0[0]};
      `PCR_A_LMODE_B: rd_mux = {7'h00, LINK_MODE_BIT0[1]};
      `PCR_A_DDC_EN: rd_mux = {7'h00, DDC_EN};
      `PCR_A_DEC_A: rd_mux = DEC_BY8[0] ? `PCR_DEC_BY8 : 8'h00;
      `PCR_A_DEC_B: rd_mux = DEC_BY8[1] ? `PCR_DEC_BY8 : 8'h00;
      `PCR_A_GAIN_A: rd_mux = {7'h00, GAIN_6DB[0]};
      `PCR_A_GAIN_B: rd_mux = {7'h00, GAIN_6DB[1]};
      `PCR_A_PDN: rd_mux = {7'h00, GLOBAL_PDN & master_pg_r};
      default: rd_mux = 8'h00;
    endcase
  end
  always @(posedge CLK_SYS) begin
    if (RST || sen_q) begin
      rd_shift_r <= 8'h00;
      rd_osel_r <= 1'b0;
      rd_load_d_r <= 1'b0;
      SDOUT <= 1'b0;
      SERIAL_DATA_PIN_O <= 1'b0;
      SERIAL_DATA_PIN_OE_N <= 1'b1;
    end else begin
      rd_load_d_r <= rd_load_r;
      rd_osel_r <= rd_load_r && osel_hit;
      if (rd_load_d_r) begin
        rd_shift_r <= rd_osel_r ? osel_rdata : rd_mux;
      end else if (sclk_fall && is_read_r && bit_cnt_r >= 5'h10) begin
        // Data changes on falling edge, host samples on rising
        // In three-wire mode the data pin turns around only for the data phase
        SDOUT <= rd_shift_r[7];
        SERIAL_DATA_PIN_O <= rd_shift_r[7];
        SERIAL_DATA_PIN_OE_N <= ~three_wire_r;
        rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      end
    end
  end
endmodule

// *** verification/pcr_chk_sva.sv ***
// Port checker for the paged register front end
module pcr_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic SEN_N,
  input wire logic SCLK,
  input wire logic SERIAL_DATA_PIN_O,
  input wire logic SERIAL_DATA_PIN_OE_N,
  input wire logic SDOUT,
  input wire logic SOFT_RST,
  input wire logic GLOBAL_PDN,
  input wire logic [1:0] DIG_RST,
  input wire logic [1:0] SCRAMBLE_EN,
  input wire logic [1:0] LINK_MODE_BIT0,
  input wire logic DDC_EN,
  input wire logic [1:0] DEC_BY8,
  input wire logic [15:0] NCO_WORD_A,
  input wire logic [15:0] NCO_WORD_B,
  input wire logic [1:0] GAIN_6DB,
  input wire logic [3:0] PIN_DIR
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idle_r;
  wire [47:0] ctl = {GLOBAL_PDN, DIG_RST, SCRAMBLE_EN, LINK_MODE_BIT0, DDC_EN, DEC_BY8,
                     NCO_WORD_A, NCO_WORD_B, GAIN_6DB, PIN_DIR};
  // Cycles since the enable pin went high; settings may only move near a frame
  always @(posedge CLK_SYS) begin
    if (RST || !SEN_N) idle_r <= 8'h00;
    else if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence pulse4;
    SOFT_RST [*4] ##1 !SOFT_RST;
  endsequence
  sequence all_clear;
    ctl == 48'h0 && SERIAL_DATA_PIN_OE_N;
  endsequence
  chk_srst_width: assert property ($rose(SOFT_RST) |-> pulse4)
    else $error("soft reset pulse width wrong");
  chk_srst_clears: assert property ($rose(SOFT_RST) |-> ##[0:6] all_clear)
    else $error("soft reset left settings");
  chk_srst_frame: assert property ($rose(SOFT_RST) |-> idle_r < 8'd12)
    else $error("soft reset outside a frame");
  chk_reset_vals: assert property ($fell(RST) |-> all_clear)
    else $error("outputs not cleared by reset");
  chk_ctl_stand: assert property ($changed(ctl) |-> idle_r < 8'd12)
    else $error("setting moved without a frame");
  chk_sdout_fall: assert property ($changed(SDOUT) |-> !SCLK)
    else $error("read data moved while clock high");
  chk_oe_frame: assert property (!SERIAL_DATA_PIN_OE_N |-> idle_r < 8'd6)
    else $error("data pin driven outside frame");
  chk_oe_fall: assert property ($fell(SERIAL_DATA_PIN_OE_N) |-> !SCLK)
    else $error("data pin drive began while clock high");
  chk_serial_data_pin_o_fall: assert property ($changed(SERIAL_DATA_PIN_O) && !SERIAL_DATA_PIN_OE_N |-> !SCLK)
    else $error("three wire data moved while clock high");
endmodule
bind pcr_top pcr_chk pcr_chk_inst (.*);

// *** verification/pcr_host.sv ***
// Host model driving serial frames into the register front end
module pcr_host (
  input wire logic clk,
  input wire logic sdout,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe_n,
  output logic sen_n,
  output logic sclk,
  output logic serial_data_pin_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;
  initial begin
    sen_n = 1'b1;
    sclk = 1'b0;
    serial_data_pin_drv = 1'b0;
  end
  // Clock stands low between frames; the released data line shows a flipped level
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] w;
    w = {rd, a, d};
    q = 8'h00;
    @(negedge clk);
    sen_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_data_pin_drv = w[i];
      repeat (HALF) @(negedge clk);
      if (i < 8) q[i] = serial_data_pin_oe_n ? sdout : serial_data_pin_o;
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    sen_n = 1'b1;
    serial_data_pin_drv = ~serial_data_pin_drv;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the paged register front end
`include "pcr_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t got %h want %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  wire sen_n, sclk, serial_data_pin_drv, serial_data_pin_o, serial_data_pin_oe_n, sdout, soft_rst, global_pdn, ddc_en;
  wire [1:0] dig_rst, scr_en, lmode, dec8, gain;
  wire [15:0] nco_a, nco_b;
  wire [3:0] pin_dir;
  wire serial_data_pin_w = serial_data_pin_oe_n ? serial_data_pin_drv : serial_data_pin_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_srst = 0;
  int n_oe = 0;
  logic [7:0] q;
  // Address, write data, expected read back; reserved bits written as zero
  logic [31:0] rows [8] = '{32'h0002_a5_a5, 32'h0027_01_01, 32'h002b_10_10,
    32'h0032_5a_5a, 32'h0035_c3_c3, 32'h0037_05_05, 32'h0100_77_00, 32'h0002_00_00};
  logic [23:0] ddc [10] = '{24'h5000_01, 24'h5001_02, 24'h5007_9a, 24'h5008_99,
    24'h5014_01, 24'h5801_02, 24'h5807_9a, 24'h5808_99, 24'h5814_01, 24'h5801_03};
  always #5 clk_sys = ~clk_sys;
  pcr_host pcr_host_inst (.clk(clk_sys), .sdout(sdout), .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe_n(serial_data_pin_oe_n), .sen_n(sen_n), .sclk(sclk), .serial_data_pin_drv(serial_data_pin_drv));
  pcr_top pcr_top_inst (.CLK_SYS(clk_sys), .RST(rst), .SEN_N(sen_n), .SCLK(sclk),
    .SERIAL_DATA_PIN_I(serial_data_pin_w), .SERIAL_DATA_PIN_O(serial_data_pin_o), .SERIAL_DATA_PIN_OE_N(serial_data_pin_oe_n), .SDOUT(sdout),
    .SOFT_RST(soft_rst), .GLOBAL_PDN(global_pdn), .DIG_RST(dig_rst), .SCRAMBLE_EN(scr_en),
    .LINK_MODE_BIT0(lmode), .DDC_EN(ddc_en), .DEC_BY8(dec8), .NCO_WORD_A(nco_a),
    .NCO_WORD_B(nco_b), .GAIN_6DB(gain), .PIN_DIR(pin_dir));
  always @(posedge clk_sys) begin
    n_srst <= n_srst + int'(soft_rst);
    n_oe <= n_oe + int'(!serial_data_pin_oe_n);
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] unused;
    pcr_host_inst.xfer(1'b0, a[14:0], d, unused);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    pcr_host_inst.xfer(1'b1, a[14:0], 8'h00, v);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // About 57 frames of 500 cycles; the limit allows about 80
  initial begin
    #400_000;
    n_mismatch++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    rd(`PCR_A_PAGE0, q);
    `CHK(q, `PCR_RST_VAL)
    $display("end reset");
    foreach (rows[i]) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], q);
      `CHK(q, rows[i][7:0])
    end
    `CHK(pin_dir, 4'h5)
    $display("end rows");
    wr(`PCR_A_SCR_A, 8'h80);
    `CHK(scr_en, 2'b00)
    wr(`PCR_A_PGSEL_HI, 8'h69);
    wr(`PCR_A_PGSEL_LO, 8'h00);
    wr(`PCR_A_SCR_A, 8'h80);
    wr(`PCR_A_SCR_B, 8'h80);
    wr(`PCR_A_LMODE_A, 8'h01);
    wr(`PCR_A_LMODE_B, 8'h01);
    `CHK({scr_en, lmode}, 4'hf)
    wr(`PCR_A_PGSEL_HI, 8'h68);
    wr(`PCR_A_DIGRST, 8'h01);
    `CHK(dig_rst, 2'b01)
    wr(`PCR_A_DIGRST, 8'h00);
    wr(`PCR_A_PGSEL_LO, 8'h01);
    wr(`PCR_A_SCR_A, 8'h00);
    wr(`PCR_A_DIGRST, 8'h01);
    `CHK({scr_en, dig_rst}, 4'he)
    wr(`PCR_A_DIGRST, 8'h00);
    wr(`PCR_A_PGSEL_HI, 8'h61);
    wr(`PCR_A_DIGRST, 8'h01);
    `CHK(dig_rst, 2'b00)
    $display("end pages");
    foreach (ddc[i]) wr(ddc[i][23:8], ddc[i][7:0]);
    `CHK({ddc_en, dec8, gain}, 5'b1_01_11)
    `CHK({nco_a, nco_b}, 32'h999a_999a)
    $display("end datapath");
    wr(`PCR_A_PDN, 8'h01);
    wr(`PCR_A_ADCPG, 8'hff);
    wr(`PCR_A_MSTPG, 8'h04);
    wr(`PCR_A_PDN, 8'h01);
    `CHK(global_pdn, 1'b0)
    wr(`PCR_A_ADCPG, 8'h00);
    wr(`PCR_A_MSTPG, 8'h04);
    wr(`PCR_A_PDN, 8'h01);
    `CHK(global_pdn, 1'b1)
    wr(`PCR_A_MSTPG, 8'h00);
    $display("end power");
    wr(`PCR_A_PORTCFG, 8'h01);
    rd(`PCR_A_OSEL4, q);
    `CHK({q, n_oe > 0}, 9'h187)
    wr(`PCR_A_PORTCFG, 8'h00);
    $display("end three wire");
    wr(`PCR_A_SWRST, 8'h01);
    `CHK({n_srst, global_pdn}, {32'd0, 1'b1})
    wr(`PCR_A_SWRST, 8'h81);
    rd(`PCR_A_SWRST, q);
    `CHK({n_srst, q, global_pdn, nco_a}, {32'd4, 25'h0})
    $display("end soft reset");
    results();
  end
endmodule
